// file: src/sar_seq_pkg.sv
// Constants shared by the converter sequencer and its clock divider.
// Assumes a 250 MHz system clock and a 12-bit successive-approximation core.
`default_nettype none
package sar_seq_pkg;
  localparam int          CLK_MHZ        = 250;
  localparam int          RESULT_W       = 12;
  localparam logic [2:0]  SRC_TIMER0     = 3'h0;
  localparam logic [2:0]  SRC_TIMER1     = 3'h1;
  localparam logic [2:0]  SRC_TIMER2     = 3'h2;
  localparam logic [2:0]  SRC_RESERVED   = 3'h3;
  localparam logic [2:0]  SRC_PIN        = 3'h4;
  localparam logic [2:0]  SRC_PIN_INV    = 3'h5;
  localparam logic [2:0]  SRC_CONTINUOUS = 3'h6;
  localparam logic [2:0]  SRC_SOFTWARE   = 3'h7;
  localparam int          START_BUSY_BIT = 3;
  // Cycle counts in converter clock ticks
  localparam logic [4:0]  SE_POWERUP_CYC = 5'd11;
  localparam logic [4:0]  CONT_PWR_CYC   = 5'd8;
  localparam logic [4:0]  ACQ_CYC        = 5'd3;
  localparam logic [4:0]  CONV_CYC       = 5'd13;
  localparam logic [4:0]  CONT_PERIOD    = 5'd16;
  // Master-enable power-up, in ns, and derived system clock count
  localparam int          MASTER_PWR_NS  = 1000;
  localparam logic [8:0]  MASTER_PWR_CYC = 9'((MASTER_PWR_NS * CLK_MHZ + 999) / 1000);
  localparam logic [1:0]  DIV_RESET      = 2'h0;
  typedef enum logic [2:0] {
    ST_OFF, ST_WAKE, ST_IDLE, ST_POWERUP, ST_TRACK, ST_CONVERT
  } seq_state_t;
endpackage : sar_seq_pkg
`default_nettype wire

// file: src/conv_clk_gen.sv
// Converter clock-enable generator: divides the system clock by 2,4,8,16.
// Assumes the divider select comes from logic on the same clock.
`default_nettype none
module conv_clk_gen (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] conv_clk_divider,
  output logic            conv_clk
);
  import sar_seq_pkg::*;
  logic [3:0] cnt_q;
  wire  [3:0] limit = 4'((5'h2 << conv_clk_divider) - 5'h1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // One-cycle tick per converter clock period
  assign conv_clk = (cnt_q >= limit);
endmodule : conv_clk_gen
`default_nettype wire

// file: src/sar_adc_conversion_sequencer.sv
// Conversion sequencer for a 12-bit successive-approximation converter.
// Assumes control bits come from processor registers on clk; pin is asynchronous.
// Behaviour
// - Converter clock divided by two-bit field.
// - Converter clock times track, hold, SAR steps.
// - Auto shutdown at ready, else back to acquire.
// - Power-up interval after auto shutdown.
// - Master enable clear: powered down, triggers ignored.
// - One microsecond power-up after master enable.
// - Result and flags kept through power-down.
// - Three-bit field selects trigger source.
// - Selected timer output drives trigger.
// - Inverted pin source complements pin level.
// - Continuous code starts, repeats every 16.
// - Software start bit, always single-edge.
// - Dual-edge: rise tracks, fall holds/converts.
// - Power-up delay only when auto-shut-down; the code also delays the first start after master enable, except in dual-edge mode.
// - Conversion takes 13 converter clocks.
// - Dual-edge inverted pin: fall tracks, rise converts.
// - Single-edge self-timed power-up and acquisition.
// - Hold after 11 cycles, or immediately.
// - Single-edge inverted pin: rising edge starts.
// - Continuous: 8 power-up, 3 track, convert.
// - Already on: acquire until edge, then convert.
// - Result stored, ready flag set on completion.
// - Interrupt only when interrupt enable set.
`default_nettype none
module sar_adc_conversion_sequencer (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic [1:0]                    conv_clk_divider,
  input  wire logic                          converter_master_en,
  input  wire logic                          auto_shutdown_en,
  input  wire logic                          dual_edge_en,
  input  wire logic [2:0]                    trigger_source_sel,
  input  wire logic                          start_busy_wr,
  input  wire logic                          conv_ready_irq_en,
  input  wire logic                          conv_ready_clr,
  input  wire logic [2:0]                    timer_out,
  input  wire logic                          ext_trigger_pin,
  input  wire logic                          comparator_out,
  output logic                               start_busy_bit,
  output logic                               conv_ready_flag,
  output logic                               conv_ready_irq,
  output logic [sar_seq_pkg::RESULT_W-1:0]   conv_result_reg,
  output logic                               analog_power_on,
  output logic                               track_hold_track,
  output logic [sar_seq_pkg::RESULT_W-1:0]   dac_code
);
  import sar_seq_pkg::*;

  logic                conv_clk;
  seq_state_t          state_q, state_d;
  logic [4:0]          cnt_q, cnt_d;
  logic [4:0]          period_q;
  logic [8:0]          wake_q;
  logic                shut_q, shut_d;
  logic                cont_run_q;
  logic [2:0]          src_q;
  logic [3:0]          s1_q, s2_q;
  logic                trig_q;
  logic                sw_pend_q;
  logic [RESULT_W-1:0] sar_q, trial_q, res_q;
  logic                rdy_q;
  logic                bit_cmp;

  conv_clk_gen u_div (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .conv_clk_divider (conv_clk_divider),
    .conv_clk         (conv_clk)
  );

  // Two-flop synchronisers for pin and timers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end else begin
      s1_q <= {ext_trigger_pin, timer_out};
      s2_q <= s1_q;
    end
  end

  wire pin_lvl  = (trigger_source_sel == SRC_PIN_INV) ? ~s2_q[3] : s2_q[3];
  wire trig_lvl = (trigger_source_sel == SRC_TIMER0) ? s2_q[0] :
                  (trigger_source_sel == SRC_TIMER1) ? s2_q[1] :
                  (trigger_source_sel == SRC_TIMER2) ? s2_q[2] :
                  (trigger_source_sel == SRC_PIN ||
                   trigger_source_sel == SRC_PIN_INV) ? pin_lvl : 1'b0;
  wire rise_now = trig_lvl & ~trig_q;
  wire fall_now = ~trig_lvl & trig_q;

  // Hardware sources: events held until the next converter clock tick
  logic rise_p_q, fall_p_q;
  wire  hw_src   = ~trigger_source_sel[2] | ~trigger_source_sel[1];
  wire  dual     = dual_edge_en & hw_src;
  // Single-edge: plain sources start on a falling edge, the inverted pin on a rising one
  wire  se_start = fall_p_q;
  wire  cont_sel = (trigger_source_sel == SRC_CONTINUOUS);
  wire  cont_new = (trigger_source_sel == SRC_CONTINUOUS) && (src_q != SRC_CONTINUOUS);
  wire  sw_start = (trigger_source_sel == SRC_SOFTWARE) && sw_pend_q;
  wire  hw_start = hw_src && (trigger_source_sel != SRC_RESERVED) &&
                   (dual ? rise_p_q : se_start);
  wire  start    = hw_start | sw_start | cont_run_q;
  wire  en_ok    = converter_master_en && (wake_q == MASTER_PWR_CYC);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_q    <= 1'b0;
      rise_p_q  <= 1'b0;
      fall_p_q  <= 1'b0;
      src_q     <= SRC_RESERVED;
      sw_pend_q <= 1'b0;
      wake_q    <= 9'h0;
    end else begin
      trig_q    <= trig_lvl;
      rise_p_q  <= rise_now | (rise_p_q & ~conv_clk);
      fall_p_q  <= fall_now | (fall_p_q & ~conv_clk);
      src_q     <= trigger_source_sel;
      sw_pend_q <= start_busy_wr | (sw_pend_q & ~(conv_clk & state_q != ST_CONVERT));
      if (!converter_master_en) begin
        wake_q <= 9'h0;
      end else if (wake_q != MASTER_PWR_CYC) begin
        wake_q <= wake_q + 9'h1;
      end
    end
  end

  // Continuous mode: armed on write of the code, then paced every 16 ticks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cont_run_q <= 1'b0;
      period_q   <= 5'h0;
    end else if (trigger_source_sel != SRC_CONTINUOUS || !en_ok) begin
      cont_run_q <= 1'b0;
      period_q   <= 5'h0;
    end else if (cont_new) begin
      cont_run_q <= 1'b1;
      period_q   <= 5'h0;
    end else if (conv_clk) begin
      if (cont_run_q && state_q == ST_IDLE) begin
        // Start taken now: pace the next one 16 ticks from here
        cont_run_q <= 1'b0;
        period_q   <= 5'h1;
      end else if (period_q != 5'h0) begin
        period_q   <= (period_q == CONT_PERIOD - 5'h1) ? 5'h0 : period_q + 5'h1;
        cont_run_q <= (period_q == CONT_PERIOD - 5'h1);
      end
    end
  end

  assign bit_cmp = comparator_out;

  // Sequencer, stepped on converter clock ticks
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shut_d  = shut_q;
    case (state_q)
      ST_OFF: begin
        if (converter_master_en) state_d = ST_WAKE;
      end
      ST_WAKE: begin
        if (en_ok) state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (start) begin
          cnt_d = 5'h0;
          if (dual) state_d = ST_TRACK;
          else if (shut_q) state_d = ST_POWERUP;
          else state_d = ST_CONVERT;
        end
      end
      ST_POWERUP: begin
        cnt_d  = cnt_q + 5'h1;
        if (cont_sel && cnt_q == CONT_PWR_CYC - 5'h1) begin
          cnt_d   = 5'h0;
          shut_d  = 1'b0;
          state_d = ST_TRACK;
        end else if (!cont_sel && cnt_q == SE_POWERUP_CYC - 5'h1) begin
          cnt_d   = 5'h0;
          shut_d  = 1'b0;
          state_d = ST_CONVERT;
        end
      end
      ST_TRACK: begin
        shut_d = 1'b0;
        cnt_d  = cnt_q + 5'h1;
        if (dual) begin
          if (rise_p_q == 1'b0 && fall_p_q) begin
            cnt_d   = 5'h0;
            state_d = ST_CONVERT;
          end
        end else if (cnt_q == ACQ_CYC - 5'h1) begin
          cnt_d   = 5'h0;
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        cnt_d = cnt_q + 5'h1;
        if (cnt_q == CONV_CYC - 5'h1) begin
          cnt_d   = 5'h0;
          shut_d  = auto_shutdown_en;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_OFF;
    endcase
    if (!converter_master_en) begin
      state_d = ST_OFF;
      shut_d  = 1'b1;
    end
  end

  wire step    = conv_clk | ~converter_master_en;
  wire conv_on = (state_q == ST_CONVERT);
  wire done    = step && conv_on && (cnt_q == CONV_CYC - 5'h1) && converter_master_en;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_OFF;
      cnt_q   <= 5'h0;
      shut_q  <= 1'b1;
    end else if (step) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shut_q  <= shut_d;
    end
  end

  // Successive approximation, one bit per converter clock, MSB first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sar_q   <= '0;
      trial_q <= '0;
    end else if (conv_clk) begin
      if (state_d == ST_CONVERT && !conv_on) begin
        sar_q   <= '0;
        trial_q <= {1'b1, {(RESULT_W-1){1'b0}}};
      end else if (conv_on && trial_q != '0) begin
        sar_q   <= bit_cmp ? (sar_q | trial_q) : sar_q;
        trial_q <= trial_q >> 1;
      end
    end
  end

  // Result and ready flag are never cleared by power-down
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      if (done) res_q <= sar_q;
      rdy_q <= done | (rdy_q & ~conv_ready_clr);
    end
  end

  assign conv_result_reg  = res_q;
  assign conv_ready_flag  = rdy_q;
  assign conv_ready_irq   = rdy_q & conv_ready_irq_en;
  assign start_busy_bit   = (state_q == ST_POWERUP) || (state_q == ST_TRACK) || conv_on ||
                            sw_pend_q;
  assign analog_power_on  = converter_master_en && !(shut_q && state_q == ST_IDLE);
  assign track_hold_track = !conv_on;
  assign dac_code         = sar_q | trial_q;
endmodule : sar_adc_conversion_sequencer
`default_nettype wire

// file: testbench/sar_seq_checker.sv
// Port-level assertions for the conversion sequencer.
// Bound to every sequencer instance; one clock domain, clk with sys_rst.
`default_nettype none
module sar_seq_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [1:0]  conv_clk_divider,
  input wire logic        converter_master_en,
  input wire logic        auto_shutdown_en,
  input wire logic        conv_ready_irq_en,
  input wire logic        conv_ready_clr,
  input wire logic        start_busy_bit,
  input wire logic        conv_ready_flag,
  input wire logic        conv_ready_irq,
  input wire logic [11:0] conv_result_reg,
  input wire logic        analog_power_on,
  input wire logic        track_hold_track
);
  logic [15:0] low_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Length of the current hold phase in system clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_q <= 16'h0;
    end else if (track_hold_track) begin
      low_cnt_q <= 16'h0;
    end else begin
      low_cnt_q <= low_cnt_q + 16'h1;
    end
  end
  property p_irq; conv_ready_irq == (conv_ready_flag && conv_ready_irq_en); endproperty
  a_irq: assert property (p_irq)
    else $error("irq differs from flag and enable");
  property p_conv_len; $rose(track_hold_track) |-> low_cnt_q == 16'(13 * (2 << conv_clk_divider));
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  property p_off; !converter_master_en [*4] |-> !analog_power_on; endproperty
  a_off: assert property (p_off)
    else $error("powered while disabled");
  property p_keep; !converter_master_en && !$past(converter_master_en) |-> $stable(conv_result_reg);
  endproperty
  a_keep: assert property (p_keep)
    else $error("result lost in power-down");
  property p_upd; $changed(conv_result_reg) |-> track_hold_track && conv_ready_flag; endproperty
  a_upd: assert property (p_upd)
    else $error("result changed without ready");
  property p_sticky; conv_ready_flag && !conv_ready_clr |=> conv_ready_flag; endproperty
  a_sticky: assert property (p_sticky)
    else $error("ready flag dropped");
  property p_busy; !track_hold_track |-> start_busy_bit && analog_power_on; endproperty
  a_busy: assert property (p_busy)
    else $error("converting while idle or unpowered");
  property p_shut; $rose(conv_ready_flag) && auto_shutdown_en |-> ##[0:1] !analog_power_on;
  endproperty
  a_shut: assert property (p_shut)
    else $error("no auto shutdown");
  property p_stay;
    $rose(conv_ready_flag) && !auto_shutdown_en && converter_master_en |-> analog_power_on;
  endproperty
  a_stay: assert property (p_stay)
    else $error("shut down without auto shutdown");
endmodule : sar_seq_checker
bind sar_adc_conversion_sequencer sar_seq_checker sar_seq_checker_i (.clk, .sys_rst,
  .conv_clk_divider, .converter_master_en, .auto_shutdown_en, .conv_ready_irq_en,
  .conv_ready_clr, .start_busy_bit, .conv_ready_flag, .conv_ready_irq, .conv_result_reg,
  .analog_power_on, .track_hold_track);
`default_nettype wire

// file: testbench/analog_front_model.sv
// Track/hold and comparator model: holds the input level when hold begins.
// Assumes the trial code is kept when it does not exceed the held level.
`default_nettype none
module analog_front_model (
  input  wire logic        clk,
  input  wire logic        track_hold_track,
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] level,
  output logic             comparator_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] held_q;
  logic        wiggle_q = 1'b0;
  always_ff @(posedge clk) begin
    wiggle_q <= ~wiggle_q;
    if (track_hold_track) held_q <= level;
  end
  // Output is meaningless while tracking, so it toggles
  assign comparator_out = track_hold_track ? wiggle_q : (dac_code <= held_q);
endmodule : analog_front_model
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the conversion sequencer.
// Assumes the comparator model stands on the analog side.
`default_nettype none
module testbench;
  import sar_seq_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1, men = 0, asd = 0, dual = 0, swr = 0, ien = 0, clr = 0, pin = 0;
  logic [1:0]  div = 2'h0;
  logic [2:0]  src = SRC_SOFTWARE, tmr = 3'h0;
  logic [11:0] sample = 12'h0;
  wire  logic  cmp, busy, flag, irq, pwr, trk;
  wire  logic [11:0] res, dac;
  int num_errors = 0, comparisons = 0, last = 0;
  int q[$];
  logic [2:0] srcs[6] = '{SRC_TIMER0, SRC_TIMER1, SRC_TIMER2, SRC_PIN, SRC_PIN_INV, SRC_SOFTWARE};
  sar_adc_conversion_sequencer sar_adc_conversion_sequencer_i (.clk(clk), .sys_rst(sys_rst),
    .conv_clk_divider(div), .converter_master_en(men), .auto_shutdown_en(asd),
    .dual_edge_en(dual), .trigger_source_sel(src), .start_busy_wr(swr),
    .conv_ready_irq_en(ien), .conv_ready_clr(clr), .timer_out(tmr), .ext_trigger_pin(pin),
    .comparator_out(cmp), .start_busy_bit(busy), .conv_ready_flag(flag),
    .conv_ready_irq(irq), .conv_result_reg(res), .analog_power_on(pwr),
    .track_hold_track(trk), .dac_code(dac));
  analog_front_model analog_front_model_i (.clk(clk), .track_hold_track(trk),
    .dac_code(dac), .level(sample), .comparator_out(cmp));
  always #2 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic summarize;
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Level 1 means trigger asserted; the inverted pin is driven low for it
  task automatic drive(input logic [2:0] s, input logic v);
    if (s < SRC_RESERVED) tmr[s[1:0]] = v;
    else pin = (s == SRC_PIN_INV) ? ~v : v;
  endtask : drive
  task automatic fire(input logic [2:0] s, input int hold);
    sample = 12'($urandom);
    q.push_back(int'(sample));
    if (s == SRC_SOFTWARE) begin
      swr = 1'b1;
      cyc(1);
      swr = 1'b0;
      chk({11'h0, busy}, 12'h1, "busy after start");
    end else begin
      drive(s, 1'b1);
      cyc(hold);
      chk({11'h0, trk}, 12'h1, "track before edge");
      drive(s, 1'b0);
    end
  endtask : fire
  task automatic await_conv(input logic done, input int lim);
    for (int i = 0; i < lim && flag !== 1'b1; i++) cyc(1);
    chk({11'h0, flag}, {11'h0, done}, "ready flag");
    chk({11'h0, irq}, {11'h0, done & ien}, "ready irq");
    chk({11'h0, busy}, 12'h0, "busy at ready");
    if (flag === 1'b1 && q.size() > 0) begin
      last = q.pop_front();
      chk(res, 12'(last), "result");
    end
    q.delete();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask : await_conv
  task automatic noise;
    tmr = 3'h7;
    pin = 1'b1;
    swr = 1'b1;
    cyc(1);
    swr = 1'b0;
    cyc(16);
    tmr = 3'h0;
    pin = 1'b0;
  endtask : noise
  initial begin
    void'($urandom(52));
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    noise();
    await_conv(1'b0, 100);
    men = 1'b1;
    cyc(260);
    for (int d = 0; d < 2; d++) begin
      div = 2'(d);
      ien = d[0];
      fire(SRC_SOFTWARE, 0);
      await_conv(1'b1, 300);
    end
    foreach (srcs[k]) begin
      src = srcs[k];
      cyc(4);
      fire(src, 16);
      await_conv(1'b1, 300);
    end
    src = SRC_RESERVED;
    noise();
    await_conv(1'b0, 100);
    dual = 1'b1;
    for (int k = 3; k < 6; k++) begin
      src = srcs[k];
      cyc(4);
      fire(src, 625);
      await_conv(1'b1, 300);
    end
    dual = 1'b0;
    men = 1'b0;
    cyc(20);
    chk(res, 12'(last), "result kept");
    men = 1'b1;
    cyc(260);
    asd = 1'b1;
    for (int k = 0; k < 2; k++) begin
      fire(SRC_SOFTWARE, 0);
      await_conv(1'b1, 400);
      chk({11'h0, pwr}, 12'h0, "power after shutdown");
    end
    asd = 1'b0;
    sample = 12'($urandom);
    src = SRC_CONTINUOUS;
    for (int k = 0; k < 3; k++) begin
      q.push_back(int'(sample));
      await_conv(1'b1, (k == 0) ? 200 : 80);
    end
    src = SRC_SOFTWARE;
    cyc(100);
    await_conv(1'b0, 1);
    summarize();
  end
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
